// ===== ppit_map.svh
// Purpose: register offsets, field positions and reset values of the port control block
// Assumes: word-aligned registers on a 32-bit classic Wishbone slave
// Notes: offsets are byte addresses
`ifndef PPIT_MAP_SVH
`define PPIT_MAP_SVH
`define PPIT_OFS_IDLE 8'h00
`define PPIT_OFS_THR 8'h04
`define PPIT_OFS_RAW 8'h08
`define PPIT_OFS_ENST 8'h0c
`define PPIT_OFS_IESET 8'h10
`define PPIT_OFS_IECLR 8'h14
`define PPIT_OFS_CTRL 8'h18
`define PPIT_IDLE_RST 32'h00000000
`define PPIT_THR_RST 32'h00000000
`define PPIT_EVT_RST 13'h0000
`define PPIT_CTRL_RST 4'h0
`define PPIT_EVT_MASK 13'h1f1f
`define PPIT_THR_MASK 32'h03030303
`define PPIT_IDLE_B_LSB 16
`define PPIT_IDLE_A_LSB 0
`define PPIT_TXB_LSB 24
`define PPIT_TXA_LSB 16
`define PPIT_RDQ_LSB 8
`define PPIT_RDI_LSB 0
`define PPIT_CTRL_MODE_A 0
`define PPIT_CTRL_MODE_B 1
`define PPIT_CTRL_HIZ_A 2
`define PPIT_CTRL_HIZ_B 3
`define PPIT_EVT_Q_LSB 8
`define PPIT_EVT_I_LSB 0
`define PPIT_SZ_64 9'h040
`define PPIT_SZ_128 9'h080
`define PPIT_SZ_256 9'h100
`endif

// ===== ppit_pkg.sv
// Purpose: shared types of the port control block
// Assumes: nothing beyond the map header
// Notes: state of the top, apart from the idle synchronisers, is a single packed struct
package ppit_pkg;
  // per-channel event bits, order end-of-line down to setup fault
  typedef enum logic [2:0] {
    EV_SETUP = 3'h0,
    EV_FLOW = 3'h1,
    EV_BUS = 3'h2,
    EV_WINDOW = 3'h3,
    EV_LINE = 3'h4
  } ppit_evt_t;

  // whole state of the top module except the input synchronisers
  typedef struct packed {
    logic [31:0] idle;
    logic [31:0] thr;
    logic [3:0] ctrl;
    logic [12:0] raw;
    logic [12:0] en;
    logic [12:0] pend;
    logic ack;
    logic [31:0] rdat;
    logic irq;
    logic [15:0] pin_a;
    logic [15:0] pin_b;
    logic oe_a;
    logic oe_b;
    logic go_a;
    logic go_b;
    logic [8:0] burst_q;
    logic [8:0] burst_i;
  } ppit_state_t;
endpackage

// ===== ppit_top.sv
// Purpose: idle values, thresholds and event status with interrupt for a two-channel port
// Assumes: one 50 MHz clock, synchronous active-low reset, classic Wishbone slave
// Notes: event inputs are same-clock pulses; level inputs from pins are synchronised
// How it works
// - idle, transmit, drive enabled: chan B idle word
// - idle, transmit, drive enabled: chan A idle word
// - chan B transmit waits for threshold bytes
// - chan A transmit waits for threshold bytes
// - threshold codes 0,1,3 give 64,128,256 bytes
// - second dma reads with its burst size
// - first dma reads with its burst size
// - raw status sets on event regardless enable
// - raw write one fakes event, zero ignored
// - status bits 12-8 second, 4-0 first dma
// - enabled status sets on event while enabled
// - enabled status reads zero while disabled
// - enabled status write one clears pending
// - bus error raises that channel error event
// - underrun or overflow raises flow fault event
// - enable-set write one enables; both read enables
// - enable-clear write one disables that event
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ppit_map.svh"

// register map, byte offsets on the slave bus:
//   0x00 idle words, B in the upper half, A in the lower half
//   0x04 start levels and burst sizes, two bits each
//   0x08 raw status, write one fakes the event
//   0x0c enabled status, write one clears
//   0x10 enable set, 0x14 enable clear, both read the enables
//   0x18 control: tx mode A, tx mode B, high-z A, high-z B
// every access answers one cycle after it is taken; ack then rests
// for one cycle, so back-to-back accesses need one idle cycle
// limitation: raw status has no software clear in this map
module ppit_top (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  // classic wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // channel idle flags from the pin side, asynchronous
  input wire logic I_IDLE_A,
  input wire logic I_IDLE_B,
  // bytes buffered per interface channel, same clock
  input wire logic [8:0] I_FILL_A,
  input wire logic [8:0] I_FILL_B,
  // event pulses, bit order line,window,bus,flow,setup
  input wire logic [4:0] I_EVT_Q,
  input wire logic [4:0] I_EVT_I,
  // idle drive to the data pins, registered
  output logic [15:0] O_DATA_A,
  output logic O_DATA_A_OE,
  output logic [15:0] O_DATA_B,
  output logic O_DATA_B_OE,
  // transmit start levels per channel
  output logic O_TX_GO_A,
  output logic O_TX_GO_B,
  // read burst sizes per dma channel
  output logic [8:0] O_BURST_Q,
  output logic [8:0] O_BURST_I,
  // level interrupt to the cpu
  output logic O_IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // the size decode is shared by both start levels and both bursts,
  // so one function keeps the four decoders identical
  // lane masking is shared by every writable register but control, which tests lane 0 itself

  // threshold code to byte count; reserved code falls back to 64
  // code 2 is reserved; software should never write it
  function automatic logic [8:0] sz_dec(input logic [1:0] code);
    case (code)
      2'h0: sz_dec = `PPIT_SZ_64;
      2'h1: sz_dec = `PPIT_SZ_128;
      2'h3: sz_dec = `PPIT_SZ_256;
      default: sz_dec = `PPIT_SZ_64; // reserved code, safest short value
    endcase
  endfunction

  // byte lanes to a bit mask
  // a zero lane leaves that byte of the target untouched
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: two flops, second only is read
  logic [1:0] idle_s1_ff;
  logic [1:0] idle_s2_ff;

  // pin idle flags cross into the clock domain
  // resets to not idle so no idle word leaks out at start
  // first stage may go metastable; nothing else reads it
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      idle_s1_ff <= 2'h0;
      idle_s2_ff <= 2'h0;
    end else begin
      idle_s1_ff <= {I_IDLE_B, I_IDLE_A};
      idle_s2_ff <= idle_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  // all registers but the idle synchronisers live in one packed struct; the comb block builds the
  // next copy and one always_ff latches it, so every output is a flop
  // trade-off: the read mux is registered too, costing a cycle of
  // latency but keeping the bus outputs glitch free
  // event pulses must last exactly one clock; longer pulses set twice
  ppit_pkg::ppit_state_t st_ff;
  ppit_pkg::ppit_state_t nxt_st;
  logic [12:0] evt_hw; // hardware events in status layout
  // decoded bus strobes
  logic acc; // bus access this cycle, first cycle only
  logic wr;
  logic [31:0] wm; // write data gated by lanes
  // channel modes from the control register
  logic mode_tx_a;
  logic mode_tx_b;

  // events map onto status bits 12-8 and 4-0
  assign evt_hw = {I_EVT_Q, 3'h0, I_EVT_I};
  // ack drops for a cycle after each answer
  assign acc = I_WB_CYC && I_WB_STB && !st_ff.ack;
  assign wr = acc && I_WB_WE;
  assign wm = I_WB_DAT & lane_mask(I_WB_SEL);
  assign mode_tx_a = st_ff.ctrl[`PPIT_CTRL_MODE_A];
  assign mode_tx_b = st_ff.ctrl[`PPIT_CTRL_MODE_B];

  // next state: registers, status, pins, interrupt
  always_comb begin
    logic [12:0] ev;
    logic [12:0] nxt_en;
    // locals take a value first so no latch is inferred
    ev = 13'h0000;
    nxt_en = st_ff.en;
    nxt_st = st_ff;
    nxt_st.ack = acc;
    // register writes
    if (wr) begin
      case (I_WB_ADR)
        // idle words, byte lanes honoured
        `PPIT_OFS_IDLE: nxt_st.idle = (st_ff.idle & ~lane_mask(I_WB_SEL)) | wm;
        // reserved threshold bits are forced to zero
        `PPIT_OFS_THR: begin
          nxt_st.thr = ((st_ff.thr & ~lane_mask(I_WB_SEL)) | wm) & `PPIT_THR_MASK;
        end
        // control lives in lane 0 only
        `PPIT_OFS_CTRL: begin
          if (I_WB_SEL[0]) begin
            nxt_st.ctrl = I_WB_DAT[3:0];
          end
        end
        // a raw write of one acts as a fake event
        `PPIT_OFS_RAW: ev = wm[12:0] & `PPIT_EVT_MASK;
        // enable set, reserved bits stay clear
        `PPIT_OFS_IESET: nxt_en = st_ff.en | (wm[12:0] & `PPIT_EVT_MASK);
        // enable clear, zeros leave enables alone
        `PPIT_OFS_IECLR: nxt_en = st_ff.en & ~wm[12:0];
        default: ;
      endcase
    end

    // hardware and simulated events join here
    ev = ev | (evt_hw & `PPIT_EVT_MASK);
    // raw is sticky and never cleared by software in this map
    nxt_st.raw = st_ff.raw | ev;
    nxt_st.en = nxt_en;

    // pending: write one clears, new event wins over the clear
    // disabling an event drops its pending bit for good
    // pending only sets if enable stood before the event
    nxt_st.pend = st_ff.pend;
    if (wr && I_WB_ADR == `PPIT_OFS_ENST) begin
      nxt_st.pend = st_ff.pend & ~wm[12:0];
    end
    nxt_st.pend = (nxt_st.pend | (ev & st_ff.en)) & nxt_en;

    // interrupt follows pending
    nxt_st.irq = |nxt_st.pend;

    // read mux
    // read data stands only in the ack cycle, zero otherwise
    // both enable addresses read the shared enable word
    nxt_st.rdat = 32'h00000000;
    if (acc && !I_WB_WE) begin
      case (I_WB_ADR)
        `PPIT_OFS_IDLE: nxt_st.rdat = st_ff.idle;
        `PPIT_OFS_THR: nxt_st.rdat = st_ff.thr;
        `PPIT_OFS_CTRL: nxt_st.rdat = {28'h0000000, st_ff.ctrl};
        `PPIT_OFS_RAW: nxt_st.rdat = {19'h00000, st_ff.raw};
        `PPIT_OFS_ENST: nxt_st.rdat = {19'h00000, st_ff.pend & st_ff.en};
        `PPIT_OFS_IESET: nxt_st.rdat = {19'h00000, st_ff.en};
        `PPIT_OFS_IECLR: nxt_st.rdat = {19'h00000, st_ff.en};
        default: nxt_st.rdat = 32'h00000000; // unmapped reads zero, still acked
      endcase
    end

    // idle drive: transmit, idle and not tri-stated
    nxt_st.pin_a = st_ff.idle[`PPIT_IDLE_A_LSB +: 16];
    nxt_st.pin_b = st_ff.idle[`PPIT_IDLE_B_LSB +: 16];
    nxt_st.oe_a = mode_tx_a && idle_s2_ff[0] && !st_ff.ctrl[`PPIT_CTRL_HIZ_A];
    nxt_st.oe_b = mode_tx_b && idle_s2_ff[1] && !st_ff.ctrl[`PPIT_CTRL_HIZ_B];

    // transmit start once threshold is buffered; no effect in receive
    // fill count is on this clock, so no synchroniser is needed
    nxt_st.go_a = mode_tx_a && (I_FILL_A >= sz_dec(st_ff.thr[`PPIT_TXA_LSB +: 2]));
    nxt_st.go_b = mode_tx_b && (I_FILL_B >= sz_dec(st_ff.thr[`PPIT_TXB_LSB +: 2]));

    // read burst sizes for the dma channels
    nxt_st.burst_q = sz_dec(st_ff.thr[`PPIT_RDQ_LSB +: 2]);
    nxt_st.burst_i = sz_dec(st_ff.thr[`PPIT_RDI_LSB +: 2]);
  end

  // single state register
  // reset clears every field; bursts show 64 one cycle after release
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  // no logic between the state flops and the pins, so output timing
  // is the same for every port
  assign O_WB_DAT = st_ff.rdat;
  assign O_WB_ACK = st_ff.ack;
  assign O_DATA_A = st_ff.pin_a;
  assign O_DATA_A_OE = st_ff.oe_a;
  assign O_DATA_B = st_ff.pin_b;
  assign O_DATA_B_OE = st_ff.oe_b;
  assign O_TX_GO_A = st_ff.go_a;
  assign O_TX_GO_B = st_ff.go_b;
  assign O_BURST_Q = st_ff.burst_q;
  assign O_BURST_I = st_ff.burst_i;
  assign O_IRQ = st_ff.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // most properties watch the registered state or outputs one edge on, a few the state as it stands;
  // events are pulses of one clock, so a |=> sees their effect exactly once
  // these are local sanity nets only; the bench carries the full scenarios
  // limitation: only a sample of bits is watched per property

  // event status
  raw_sets_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (I_EVT_I[0]) |=> st_ff.raw[0]) else $error("raw bit missed event");

  raw_fake_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (wr && I_WB_ADR == `PPIT_OFS_RAW && I_WB_SEL[1] && I_WB_DAT[12])
    |=> st_ff.raw[12]) else $error("raw write one did not set");

  bus_fault_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    I_EVT_Q[2] |=> st_ff.raw[10]) else $error("bus fault not raised");

  flow_fault_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    I_EVT_I[1] |=> st_ff.raw[1]) else $error("flow fault not raised");

  raw_keep_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    st_ff.raw[3] |=> st_ff.raw[3]) else $error("raw bit lost");

  resv_zero_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (st_ff.raw[7:5] == 3'h0) && (st_ff.pend[7:5] == 3'h0)) else $error("reserved set");

  pend_sets_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (I_EVT_Q[1] && st_ff.en[9] && !wr) |=> st_ff.pend[9]) else $error("pending missed");

  pend_off_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    !st_ff.en[4] |-> !st_ff.pend[4]) else $error("pending while disabled");

  pend_clr_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (wr && I_WB_ADR == `PPIT_OFS_ENST && I_WB_SEL[0] && I_WB_DAT[0] && !I_EVT_I[0])
    |=> !st_ff.pend[0]) else $error("pending not cleared");

  pend_keep_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (wr && I_WB_ADR == `PPIT_OFS_ENST && !I_WB_DAT[4] && st_ff.pend[4])
    |=> st_ff.pend[4]) else $error("write zero cleared pending");

  // enables, interrupt and ack
  en_set_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (wr && I_WB_ADR == `PPIT_OFS_IESET && I_WB_SEL[0] && I_WB_DAT[2])
    |=> st_ff.en[2]) else $error("enable set failed");

  en_keep_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (wr && I_WB_ADR == `PPIT_OFS_IESET && st_ff.en[11])
    |=> st_ff.en[11]) else $error("enable lost on set write");

  en_clr_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (wr && I_WB_ADR == `PPIT_OFS_IECLR && I_WB_SEL[1] && I_WB_DAT[10])
    |=> !st_ff.en[10]) else $error("enable clear failed");

  irq_tie_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    O_IRQ == |(st_ff.pend & st_ff.en)) else $error("irq mismatch");

  ack_pulse_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    O_WB_ACK |=> !O_WB_ACK) else $error("ack held two cycles");

  // pins and thresholds
  idle_b_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (O_DATA_B_OE |-> $past(st_ff.ctrl[`PPIT_CTRL_MODE_B]))) else $error("b drives in rx");

  idle_b_val_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    O_DATA_B == $past(st_ff.idle[`PPIT_IDLE_B_LSB +: 16])) else $error("b idle word wrong");

  idle_a_hiz_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    st_ff.ctrl[`PPIT_CTRL_HIZ_A] |=> !O_DATA_A_OE) else $error("a drives in high-z");

  go_a_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (mode_tx_a && st_ff.thr[17:16] == 2'h3 && I_FILL_A < 9'h100) |=> !O_TX_GO_A)
    else $error("a started early");

  go_a_rx_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    !mode_tx_a |=> !O_TX_GO_A) else $error("a started in rx");

  go_b_rx_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    !mode_tx_b |=> !O_TX_GO_B) else $error("b started in rx");

  thr_resv_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (st_ff.thr & ~`PPIT_THR_MASK) == 32'h00000000) else $error("threshold reserved set");

  resv_code_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (st_ff.thr[9:8] == 2'h2) |=> (O_BURST_Q == 9'h040)) else $error("reserved code size");

  burst_q_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (st_ff.thr[9:8] == 2'h1) |=> (O_BURST_Q == 9'h080)) else $error("burst q wrong");

  burst_i_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (st_ff.thr[1:0] == 2'h3) |=> (O_BURST_I == 9'h100)) else $error("burst i wrong");
endmodule

// ===== ppit_top_tb_top.sv
// Purpose: self-checking bench for the port control block over classic Wishbone
// Assumes: ack one cycle after the taking edge; event pulses last one clock
// Notes: the bench drives all inputs itself; sel stays on all four lanes
`timescale 1ns/1ps
`include "ppit_map.svh"

module ppit_top_tb_top;
  logic ref_clk, rst_n, cyc, stb, we, idle_a, idle_b, go_a, go_b, oe_a, oe_b, ack, irq;
  logic [7:0] adr; // byte address
  logic [3:0] sel; // all lanes, never narrowed
  logic [31:0] wdat, rdat, q, m; // q holds the data word sampled at the last ack, reads and writes alike
  logic [8:0] fill_a, fill_b, bq, bi, sz;
  logic [4:0] evq, evi; // event pulses per dma channel
  logic [15:0] da, db;
  logic [31:0] rawx; // sticky raw image the bench expects
  int failures, checked;

  ////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  ppit_top dut (.I_REF_CLK(ref_clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .I_IDLE_A(idle_a), .I_IDLE_B(idle_b), .I_FILL_A(fill_a),
    .I_FILL_B(fill_b), .I_EVT_Q(evq), .I_EVT_I(evi), .O_DATA_A(da), .O_DATA_A_OE(oe_a),
    .O_DATA_B(db), .O_DATA_B_OE(oe_b), .O_TX_GO_A(go_a), .O_TX_GO_B(go_b),
    .O_BURST_Q(bq), .O_BURST_I(bi), .O_IRQ(irq));

  ////////////////////////////////////////////////////////////////////////////
  // verdict and run end, the only exit
  task end_sim;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // compare with case equality so an unknown never matches
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (ack !== 1'b1) begin
      failures++;
      end_sim;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h00000000);
    chk(q, exp);
  endtask

  // let registered outputs land, then look just after the edge
  task settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // one-clock event pulse, mask in status bit layout
  task pulse(input logic [31:0] e);
    @(posedge ref_clk);
    evq <= e[12:8];
    evi <= e[4:0];
    @(posedge ref_clk);
    evq <= 5'h00;
    evi <= 5'h00;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    {cyc, stb, we, idle_a, idle_b} = 5'h00;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h00000000;
    {fill_a, fill_b} = 18'h00000;
    {evq, evi} = 10'h000;
    failures = 0;
    checked = 0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values, then an unmapped place reads zero
    for (int k = 0; k < 7; k++) begin
      rdchk(8'(k * 4), 32'h00000000);
    end
    rdchk(8'h40, 32'h00000000);
    chk(32'(bq), 32'h00000040);
    // reserved threshold bits read zero
    wb(1'b1, `PPIT_OFS_THR, 32'hffffffff);
    rdchk(`PPIT_OFS_THR, 32'h03030303);
    // receive mode ignores the start level
    wb(1'b1, `PPIT_OFS_CTRL, 32'h00000000);
    fill_a <= 9'h100;
    fill_b <= 9'h100;
    settle(2);
    chk(32'({go_b, go_a}), 32'h00000000);
    // every code, start level boundary on both channels
    wb(1'b1, `PPIT_OFS_CTRL, 32'h00000003);
    for (int c = 0; c < 4; c++) begin
      sz = (c == 1) ? 9'h080 : (c == 3) ? 9'h100 : 9'h040;
      wb(1'b1, `PPIT_OFS_THR, {4{6'h00, 2'(c)}});
      fill_a <= sz - 9'h001;
      fill_b <= sz;
      settle(2);
      chk(32'({bq, bi}), 32'({sz, sz}));
      chk(32'({go_b, go_a}), 32'h00000002);
      fill_a <= sz;
      fill_b <= sz - 9'h001;
      settle(2);
      chk(32'({go_b, go_a}), 32'h00000001);
    end
    // idle words driven only when idle, transmitting and not high-z
    wb(1'b1, `PPIT_OFS_IDLE, 32'hbeef1234);
    rdchk(`PPIT_OFS_IDLE, 32'hbeef1234);
    idle_a <= 1'b1;
    idle_b <= 1'b1;
    settle(5);
    chk({db, da}, 32'hbeef1234);
    chk(32'({oe_b, oe_a}), 32'h00000003);
    wb(1'b1, `PPIT_OFS_CTRL, 32'h00000007);
    settle(2);
    chk(32'({oe_b, oe_a}), 32'h00000002);
    wb(1'b1, `PPIT_OFS_CTRL, 32'h0000000b);
    settle(2);
    chk(32'({oe_b, oe_a}), 32'h00000001);
    wb(1'b1, `PPIT_OFS_CTRL, 32'h00000003);
    idle_b <= 1'b0;
    settle(5);
    chk(32'({oe_b, oe_a}), 32'h00000001);
    wb(1'b1, `PPIT_OFS_CTRL, 32'h00000000);
    settle(2);
    chk(32'({oe_b, oe_a}), 32'h00000000);
    // each event: raw while disabled, then pending, clear, disable
    rawx = 32'h00000000;
    for (int k = 0; k < 10; k++) begin
      m = 32'h00000001 << ((k < 5) ? k : k + 3);
      rawx = rawx | m;
      pulse(m);
      rdchk(`PPIT_OFS_RAW, rawx);
      rdchk(`PPIT_OFS_ENST, 32'h00000000);
      chk(32'(irq), 32'h00000000);
      wb(1'b1, `PPIT_OFS_IESET, m);
      pulse(m);
      rdchk(`PPIT_OFS_ENST, m);
      chk(32'(irq), 32'h00000001);
      wb(1'b1, `PPIT_OFS_ENST, 32'h00000000);
      rdchk(`PPIT_OFS_ENST, m);
      wb(1'b1, `PPIT_OFS_ENST, m);
      rdchk(`PPIT_OFS_ENST, 32'h00000000);
      chk(32'(irq), 32'h00000000);
      wb(1'b1, `PPIT_OFS_IECLR, m);
      rdchk(`PPIT_OFS_IECLR, 32'h00000000);
    end
    // shared enables, faked events, partial disable
    wb(1'b1, `PPIT_OFS_IESET, 32'hffffffff);
    rdchk(`PPIT_OFS_IESET, 32'h00001f1f);
    rdchk(`PPIT_OFS_IECLR, 32'h00001f1f);
    wb(1'b1, `PPIT_OFS_RAW, 32'h00000000);
    rdchk(`PPIT_OFS_ENST, 32'h00000000);
    wb(1'b1, `PPIT_OFS_RAW, 32'hffffffff);
    rdchk(`PPIT_OFS_ENST, 32'h00001f1f);
    chk(32'(irq), 32'h00000001);
    wb(1'b1, `PPIT_OFS_IECLR, 32'h00000100);
    rdchk(`PPIT_OFS_IESET, 32'h00001e1f);
    rdchk(`PPIT_OFS_ENST, 32'h00001e1f);
    wb(1'b1, `PPIT_OFS_IECLR, 32'hffffffff);
    settle(1);
    chk(32'(irq), 32'h00000000);
    end_sim;
  end
endmodule
